// ===== hdl/cis_slot_tracker.sv
// one active and one pending interrupt slot with lost detection
`timescale 1ns/100ps
module cis_slot_tracker
    import cis_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    input  wire logic req,
    input  wire logic done,
    output logic      executing,
    output logic      pending,
    output logic      start,
    output logic      lost_set
);

    cis_slot_state_t state_ff;
    cis_slot_state_t nxt_state;
    logic            nxt_start;
    logic            nxt_lost;

    always_comb begin
        nxt_state = state_ff;
        nxt_start = 1'b0;
        nxt_lost  = 1'b0;
        case (state_ff)
            CIS_IDLE: begin
                if (req) begin
                    nxt_state = CIS_ACTIVE;
                    nxt_start = 1'b1;
                end
            end
            CIS_ACTIVE: begin
                if (done && req) begin
                    nxt_start = 1'b1;
                end else if (done) begin
                    nxt_state = CIS_IDLE;
                end else if (req) begin
                    nxt_state = CIS_ACT_PEND;
                end
            end
            CIS_ACT_PEND: begin
                if (done) begin
                    nxt_state = req ? CIS_ACT_PEND : CIS_ACTIVE;
                    nxt_start = 1'b1;
                end else if (req) begin
                    nxt_lost = 1'b1;
                end
            end
            default: begin
                nxt_state = CIS_IDLE;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff  <= CIS_IDLE;
            executing <= 1'b0;
            pending   <= 1'b0;
            start     <= 1'b0;
            lost_set  <= 1'b0;
        end else if (ce) begin
            state_ff  <= nxt_state;
            executing <= (nxt_state != CIS_IDLE);
            pending   <= (nxt_state == CIS_ACT_PEND);
            start     <= nxt_start;
            lost_set  <= nxt_lost;
        end
    end

endmodule : cis_slot_tracker

// ===== hdl/cis_top.sv
// counter interrupt status block with session lock, password gate and axi4-lite registers
`timescale 1ns/100ps
module cis_top
    import cis_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                ce,
    // counter events and handler completion
    input  wire cis_trig_t           trig,
    input  wire logic                service_done,
    output logic                     irq_executing,
    output logic                     irq_pending,
    output logic                     service_start,
    output logic                     irq,
    // client session requests
    input  wire logic                sess_valid,
    input  wire cis_sess_req_t       sess_req,
    output cis_sess_rsp_t            sess_rsp,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic [2:0]          s_axi_awprot,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [DATA_W-1:0]   s_axi_wdata,
    input  wire logic [STRB_W-1:0]   s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic [2:0]          s_axi_arprot,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [DATA_W-1:0]        s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready
);

    // word-aligned address match
    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
        reg_hit = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    endfunction : reg_hit

    function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
        reg_mapped = reg_hit(addr, OFS_CTRL) || reg_hit(addr, OFS_FLAGS) ||
                     reg_hit(addr, OFS_EVT_STS) || reg_hit(addr, OFS_EVT_MSK) ||
                     reg_hit(addr, OFS_PASSWORD) || reg_hit(addr, OFS_SESSION);
    endfunction : reg_mapped

    // byte-lane merge of write data into an old value
    function automatic logic [DATA_W-1:0] strb_merge(input logic [DATA_W-1:0] old_v,
                                                     input logic [DATA_W-1:0] new_v,
                                                     input logic [STRB_W-1:0] strb);
        logic [DATA_W-1:0] res;
        res = old_v;
        for (int i = 0; i < STRB_W; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        strb_merge = res;
    endfunction : strb_merge

    logic                  aw_held_ff;
    logic [ADDR_W-1:0]     aw_addr_ff;
    logic                  w_held_ff;
    logic [DATA_W-1:0]     w_data_ff;
    logic [STRB_W-1:0]     w_strb_ff;
    logic                  wr_fire;
    logic                  wr_lane0;

    logic                  ctrl_en_ff;
    logic                  ctrl_ovf_msk_ff;
    logic                  lost_ff;
    logic [EVT_W-1:0]      evt_sts_ff;
    logic [EVT_W-1:0]      evt_msk_ff;
    logic [EVT_W-1:0]      evt_set;
    logic [KEY_W-1:0]      password_ff;
    logic [KEY_W-1:0]      nxt_password;
    logic                  pw_set_ff;

    logic                  owned_ff;
    logic [ID_W-1:0]       owner_ff;
    logic                  authed_ff;
    logic                  is_owner;
    logic                  xfer_refused;

    logic                  slot_req;
    logic                  slot_lost;
    logic [DATA_W-1:0]     rd_mux;

    // axi write channels
    assign wr_fire  = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign wr_lane0 = wr_fire && w_strb_ff[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff    <= 1'b0;
            aw_addr_ff    <= OFS_CTRL;
            s_axi_awready <= 1'b1;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff    <= 1'b1;
                aw_addr_ff    <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (wr_fire) begin
                aw_held_ff    <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_ff    <= 1'b0;
            w_data_ff    <= DATA_ZERO;
            w_strb_ff    <= '0;
            s_axi_wready <= 1'b1;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff    <= 1'b1;
                w_data_ff    <= s_axi_wdata;
                w_strb_ff    <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (wr_fire) begin
                w_held_ff    <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (ce) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= reg_mapped(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_en_ff      <= CTRL_EN_RST;
            ctrl_ovf_msk_ff <= CTRL_OVF_MSK_RST;
        end else if (ce) begin
            if (wr_lane0 && reg_hit(aw_addr_ff, OFS_CTRL)) begin
                ctrl_en_ff      <= w_data_ff[CTRL_EN_BIT];
                ctrl_ovf_msk_ff <= w_data_ff[CTRL_OVF_MSK_BIT];
            end
        end
    end

    // trigger qualification
    assign slot_req = ctrl_en_ff && (trig.low_preset || trig.high_preset || trig.underflow ||
                                     (trig.overflow && ctrl_ovf_msk_ff));

    cis_slot_tracker u_slot (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .req       (slot_req),
        .done      (service_done),
        .executing (irq_executing),
        .pending   (irq_pending),
        .start     (service_start),
        .lost_set  (slot_lost)
    );

    // lost flag: set by hardware, written by software, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lost_ff <= 1'b0;
        end else if (ce) begin
            if (slot_lost) begin
                lost_ff <= 1'b1;
            end else if (wr_lane0 && reg_hit(aw_addr_ff, OFS_FLAGS)) begin
                lost_ff <= w_data_ff[FLG_LS_BIT];
            end
        end
    end

    // sticky events, write one to clear, set wins
    assign evt_set[EVT_START_BIT]  = service_start;
    assign evt_set[EVT_LOST_BIT]   = slot_lost;
    assign evt_set[EVT_REFUSE_BIT] = xfer_refused;

    generate
        for (genvar g = 0; g < EVT_W; g++) begin : g_evt
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    evt_sts_ff[g] <= EVT_RST[g];
                end else if (ce) begin
                    if (evt_set[g]) begin
                        evt_sts_ff[g] <= 1'b1;
                    end else if (wr_lane0 && reg_hit(aw_addr_ff, OFS_EVT_STS) && w_data_ff[g]) begin
                        evt_sts_ff[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_msk_ff <= EVT_RST;
        end else if (ce) begin
            if (wr_lane0 && reg_hit(aw_addr_ff, OFS_EVT_MSK)) begin
                evt_msk_ff <= w_data_ff[EVT_W-1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(evt_sts_ff & evt_msk_ff);
        end
    end

    // password store; zero means no password
    assign nxt_password = strb_merge(password_ff, w_data_ff, w_strb_ff);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            password_ff <= KEY_NONE;
            pw_set_ff   <= 1'b0;
        end else if (ce) begin
            if (wr_fire && reg_hit(aw_addr_ff, OFS_PASSWORD)) begin
                password_ff <= nxt_password;
                pw_set_ff   <= (nxt_password != KEY_NONE);
            end
        end
    end

    // client session lock and transfer gate
    assign is_owner     = owned_ff && (owner_ff == sess_req.id);
    assign xfer_refused = ce && sess_valid && (sess_req.op == CIS_OP_XFER) &&
                          !(is_owner && (!pw_set_ff || authed_ff));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            owned_ff  <= 1'b0;
            owner_ff  <= ID_RST;
            authed_ff <= 1'b0;
            sess_rsp  <= '0;
        end else if (ce) begin
            sess_rsp.ack <= sess_valid;
            sess_rsp.ok  <= 1'b0;
            if (wr_fire && reg_hit(aw_addr_ff, OFS_PASSWORD)) begin
                authed_ff <= 1'b0;
            end
            if (sess_valid) begin
                case (sess_req.op)
                    CIS_OP_CLAIM: begin
                        if (!owned_ff || is_owner) begin
                            owned_ff    <= 1'b1;
                            owner_ff    <= sess_req.id;
                            sess_rsp.ok <= 1'b1;
                        end
                    end
                    CIS_OP_RELEASE: begin
                        if (is_owner) begin
                            owned_ff    <= 1'b0;
                            authed_ff   <= 1'b0;
                            sess_rsp.ok <= 1'b1;
                        end
                    end
                    CIS_OP_AUTH: begin
                        if (is_owner && pw_set_ff && (sess_req.key == password_ff)) begin
                            authed_ff   <= 1'b1;
                            sess_rsp.ok <= 1'b1;
                        end
                    end
                    CIS_OP_XFER: begin
                        sess_rsp.ok <= !xfer_refused;
                    end
                    default: begin
                        sess_rsp.ok <= 1'b0;
                    end
                endcase
            end
        end
    end

    // read data mux
    always_comb begin
        rd_mux = DATA_ZERO;
        if (reg_hit(s_axi_araddr, OFS_CTRL)) begin
            rd_mux[CTRL_EN_BIT]      = ctrl_en_ff;
            rd_mux[CTRL_OVF_MSK_BIT] = ctrl_ovf_msk_ff;
        end else if (reg_hit(s_axi_araddr, OFS_FLAGS)) begin
            rd_mux[FLG_EN_BIT] = ctrl_en_ff;
            rd_mux[FLG_EX_BIT] = irq_executing;
            rd_mux[FLG_PE_BIT] = irq_pending;
            rd_mux[FLG_LS_BIT] = lost_ff;
        end else if (reg_hit(s_axi_araddr, OFS_EVT_STS)) begin
            rd_mux[EVT_W-1:0] = evt_sts_ff;
        end else if (reg_hit(s_axi_araddr, OFS_EVT_MSK)) begin
            rd_mux[EVT_W-1:0] = evt_msk_ff;
        end else if (reg_hit(s_axi_araddr, OFS_SESSION)) begin
            rd_mux[SESS_OWNED_BIT]                = owned_ff;
            rd_mux[SESS_PWSET_BIT]                = pw_set_ff;
            rd_mux[SESS_AUTH_BIT]                 = authed_ff;
            rd_mux[SESS_ID_LSB +: ID_W]           = owner_ff;
        end
    end

    // axi read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= DATA_ZERO;
            s_axi_rresp   <= RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_mux;
                s_axi_rresp   <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule : cis_top

// ===== include/cis_pkg.sv
// constants, types and register map for the counter interrupt status block
package cis_pkg;

    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned STRB_W       = DATA_W / 8;
    localparam int unsigned ID_W         = 8;
    localparam int unsigned KEY_W        = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FLAGS    = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_EVT_STS  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_EVT_MSK  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PASSWORD = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_SESSION  = 8'h14;

    // control register fields
    localparam int unsigned CTRL_EN_BIT      = 0;
    localparam int unsigned CTRL_OVF_MSK_BIT = 1;
    localparam logic        CTRL_EN_RST      = 1'h0;
    localparam logic        CTRL_OVF_MSK_RST = 1'h0;

    // status flag register fields
    localparam int unsigned FLG_EN_BIT = 0;
    localparam int unsigned FLG_EX_BIT = 1;
    localparam int unsigned FLG_PE_BIT = 2;
    localparam int unsigned FLG_LS_BIT = 3;

    // sticky event bits
    localparam int unsigned EVT_W          = 3;
    localparam int unsigned EVT_START_BIT  = 0;
    localparam int unsigned EVT_LOST_BIT   = 1;
    localparam int unsigned EVT_REFUSE_BIT = 2;
    localparam logic [EVT_W-1:0] EVT_RST   = 3'h0;

    // session register fields
    localparam int unsigned SESS_OWNED_BIT = 0;
    localparam int unsigned SESS_PWSET_BIT = 1;
    localparam int unsigned SESS_AUTH_BIT  = 2;
    localparam int unsigned SESS_ID_LSB    = 8;

    localparam logic [KEY_W-1:0]  KEY_NONE  = 32'h0000_0000;
    localparam logic [ID_W-1:0]   ID_RST    = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic low_preset;
        logic high_preset;
        logic overflow;
        logic underflow;
    } cis_trig_t;

    typedef enum logic [1:0] {
        CIS_OP_CLAIM   = 2'h0,
        CIS_OP_RELEASE = 2'h1,
        CIS_OP_AUTH    = 2'h2,
        CIS_OP_XFER    = 2'h3
    } cis_op_t;

    typedef struct packed {
        cis_op_t          op;
        logic [ID_W-1:0]  id;
        logic [KEY_W-1:0] key;
    } cis_sess_req_t;

    typedef struct packed {
        logic ack;
        logic ok;
    } cis_sess_rsp_t;

    typedef enum logic [1:0] {
        CIS_IDLE     = 2'h0,
        CIS_ACTIVE   = 2'h1,
        CIS_ACT_PEND = 2'h3
    } cis_slot_state_t;

endpackage : cis_pkg

// ===== tb/cis_checker.sv
// assertion checker for the counter interrupt status block
`timescale 1ns/100ps
module cis_checker
    import cis_pkg::*;
(
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          ce,
    input  wire cis_trig_t     trig,
    input  wire logic          service_done,
    input  wire logic          irq_executing,
    input  wire logic          irq_pending,
    input  wire logic          service_start,
    input  wire logic          sess_valid,
    input  wire cis_sess_rsp_t sess_rsp
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence done_pend_s;
        irq_pending && service_done && ce && (trig == '0);
    endsequence
    sequence promoted_s;
        !irq_pending && irq_executing && service_start;
    endsequence

    start_has_exec_a: assert property (service_start |-> irq_executing)
        else $error("start pulse without an active slot");
    idle_stays_quiet_a: assert property (!irq_executing && (trig == '0) && ce |=> !service_start && !irq_executing)
        else $error("servicing began without a trigger");
    exec_holds_a: assert property (irq_executing && !service_done && ce |=> irq_executing)
        else $error("executing dropped before completion");
    exec_clears_a: assert property (irq_executing && !irq_pending && service_done && ce && (trig == '0)
        |=> !irq_executing && !service_start)
        else $error("executing not cleared after completion");
    pend_holds_a: assert property (irq_pending && !service_done && ce |=> irq_pending)
        else $error("pending dropped while active slot busy");
    pend_needs_exec_a: assert property (irq_pending |-> irq_executing)
        else $error("pending without an active slot");
    pend_promote_a: assert property (done_pend_s |=> promoted_s)
        else $error("pending request not promoted");
    sess_answer_a: assert property (sess_valid && ce |=> sess_rsp.ack)
        else $error("session request not answered");
endmodule : cis_checker

bind cis_top cis_checker u_cis_checker (.aclk, .aresetn, .ce, .trig, .service_done, .irq_executing, .irq_pending,
    .service_start, .sess_valid, .sess_rsp);

// ===== tb/testbench.sv
// self-checking bench for the counter interrupt status block
`timescale 1ns/100ps
module testbench;
    import cis_pkg::*;
    localparam logic [ADDR_W-1:0] RST_OFS [6] = '{OFS_CTRL, OFS_FLAGS, OFS_EVT_STS, OFS_EVT_MSK, OFS_PASSWORD,
                                                  OFS_SESSION};
    logic              aclk         = 1'b0;
    logic              aresetn      = 1'b0;
    cis_trig_t         trig         = '0;
    logic              service_done = 1'b0;
    logic              sess_valid   = 1'b0, ce = 1'b1;
    cis_sess_req_t     sess_req     = '0;
    cis_sess_rsp_t     sess_rsp;
    logic              irq_executing, irq_pending, service_start, irq;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata  = '0, rdata;
    logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp;
    int                miscompares  = 0;
    int                num_checks   = 0;

    always #25 aclk = ~aclk;

    cis_top u_cis_top (
        .aclk(aclk), .aresetn(aresetn), .ce(ce), .trig(trig), .service_done(service_done),
        .irq_executing(irq_executing), .irq_pending(irq_pending), .service_start(service_start), .irq(irq),
        .sess_valid(sess_valid), .sess_req(sess_req), .sess_rsp(sess_rsp),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic hang();
        miscompares++;
        $display("ERROR %0t: wait timed out", $time);
        stop_test();
    endtask : hang

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            if (n++ == 50) hang();
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        check({30'h0, bresp}, {30'h0, er});
        @(posedge aclk);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            if (n++ == 50) hang();
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        check(rdata, ed);
        check({30'h0, rresp}, {30'h0, er});
        @(posedge aclk);
    endtask : axi_rd

    task automatic step(input cis_trig_t t, input logic d, input logic [2:0] e);
        trig         <= t;
        service_done <= d;
        @(posedge aclk);
        trig         <= '0;
        service_done <= 1'b0;
        @(posedge aclk);
        check({29'h0, irq_executing, irq_pending, service_start}, {29'h0, e});
    endtask : step

    task automatic sess(input cis_op_t op, input logic [7:0] id, input logic [31:0] key, input logic ok);
        sess_valid <= 1'b1;
        sess_req   <= {op, id, key};
        @(posedge aclk);
        sess_valid <= 1'b0;
        @(posedge aclk);
        check({30'h0, sess_rsp.ack, sess_rsp.ok}, {30'h0, 1'b1, ok});
    endtask : sess

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 6; i++) axi_rd(RST_OFS[i], DATA_ZERO, RESP_OKAY);
        axi_rd(8'h40, DATA_ZERO, RESP_SLVERR);
        axi_wr(8'h40, 32'hFFFF_FFFF, RESP_SLVERR);
        step(4'h8, 1'b0, 3'h0);
        axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
        axi_wr(OFS_FLAGS, 32'h7, RESP_OKAY);
        axi_rd(OFS_FLAGS, 32'h1, RESP_OKAY);
        step(4'h2, 1'b0, 3'h0);
        step(4'h8, 1'b0, 3'h5);
        step(4'h4, 1'b0, 3'h6);
        step(4'h1, 1'b0, 3'h6);
        axi_rd(OFS_FLAGS, 32'hF, RESP_OKAY);
        step(4'h0, 1'b1, 3'h5);
        step(4'h0, 1'b1, 3'h0);
        axi_wr(OFS_CTRL, 32'h3, RESP_OKAY);
        step(4'h2, 1'b0, 3'h5);
        step(4'h8, 1'b1, 3'h5);
        step(4'h8, 1'b0, 3'h6);
        step(4'h8, 1'b1, 3'h7);
        step(4'h0, 1'b1, 3'h5);
        step(4'h0, 1'b1, 3'h0);
        ce <= 1'b0;
        step(4'h8, 1'b0, 3'h0);
        ce <= 1'b1;
        axi_wr(OFS_FLAGS, 32'h0, RESP_OKAY);
        axi_rd(OFS_FLAGS, 32'h1, RESP_OKAY);
        axi_wr(OFS_FLAGS, 32'h8, RESP_OKAY);
        axi_rd(OFS_FLAGS, 32'h9, RESP_OKAY);
        axi_wr(OFS_FLAGS, 32'h0, RESP_OKAY);
        axi_rd(OFS_EVT_STS, 32'h3, RESP_OKAY);
        axi_wr(OFS_EVT_MSK, 32'h2, RESP_OKAY);
        check({31'h0, irq}, 32'h1);
        axi_wr(OFS_EVT_STS, 32'h2, RESP_OKAY);
        check({31'h0, irq}, 32'h0);
        axi_rd(OFS_EVT_STS, 32'h1, RESP_OKAY);
        axi_wr(OFS_EVT_MSK, 32'h1, RESP_OKAY);
        check({31'h0, irq}, 32'h1);
        axi_wr(OFS_EVT_MSK, 32'h0, RESP_OKAY);
        check({31'h0, irq}, 32'h0);
        sess(CIS_OP_CLAIM, 8'h05, KEY_NONE, 1'b1);
        sess(CIS_OP_CLAIM, 8'h06, KEY_NONE, 1'b0);
        sess(CIS_OP_XFER, 8'h05, KEY_NONE, 1'b1);
        axi_wr(OFS_PASSWORD, 32'h1234_5678, RESP_OKAY);
        axi_rd(OFS_SESSION, 32'h0000_0503, RESP_OKAY);
        sess(CIS_OP_XFER, 8'h05, KEY_NONE, 1'b0);
        sess(CIS_OP_AUTH, 8'h05, 32'h1234_5679, 1'b0);
        sess(CIS_OP_AUTH, 8'h06, 32'h1234_5678, 1'b0);
        sess(CIS_OP_AUTH, 8'h05, 32'h1234_5678, 1'b1);
        sess(CIS_OP_XFER, 8'h06, KEY_NONE, 1'b0);
        sess(CIS_OP_XFER, 8'h05, KEY_NONE, 1'b1);
        axi_rd(OFS_EVT_STS, 32'h5, RESP_OKAY);
        sess(CIS_OP_RELEASE, 8'h06, KEY_NONE, 1'b0);
        sess(CIS_OP_RELEASE, 8'h05, KEY_NONE, 1'b1);
        sess(CIS_OP_CLAIM, 8'h06, KEY_NONE, 1'b1);
        stop_test();
    end
endmodule : testbench
